// ---- verilog/pmr_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Management frame decoder and two PHY register sets
// ----------------------------------------------------------------
// Functional notes
// RL1: PHY one answers at management address 1, PHY two at address 2.
// RL2: Only indices 0-5, 0x1D and 0x1F exist; others unsupported. Only 0-4 are built here; 5, 0x1D and 0x1F read zero.
// RL3: Control bit 14 enables cross-port loopback; resets to zero.
// RL4: Port 1 loopback wraps port 2 receive traffic back out port 2.
// RL5: Port 2 loopback wraps port 1 receive traffic back out port 1.
// RL6: Control fields share storage with switch registers 28/29/31 and 44/45/47.
// RL7: Control bit 4 moves transmission onto the receive pin pair.
// RL8: Control bit 3 disables automatic crossover; reset keeps it enabled.
// RL9: Control bit 5 picks crossover algorithm; one selects first; resets one.
// RL10: Control bit 2 disables far-end fault detection; default normal.
// RL11: Status bits 14 to 11 always read one.
// RL12: Status bit 15 always reads zero.
// RL13: Status bit 5 shows negotiation finished; resets zero.
// RL14: Status bit 4 shows a detected far-end fault.
// RL15: Status bit 3 follows the negotiation enable setting.
// RL16: Status bit 0 reads zero, no extended registers.
// RL17: Indices 2 and 3 return fixed identifier upper and lower halves.
// RL18: Advertisement bit 10 offers pause; resets one; mirrors port bit 4.
// RL19: Advertisement bits 8 to 5 offer speed and duplex abilities; reset one.
// RL20: Writes to fixed, reserved or unsupported bits are ignored.
// RL21: Controller reads back after writing to confirm stored values.
module pmr_top
  import pmr_pkg::*;
#(
  parameter logic [15:0] ID_UPPER = 16'ha5a0,  // Arbitrary value
  parameter logic [15:0] ID_LOWER = 16'h0f10   // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Management link
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_n,
  // Switch register side
  input  wire logic       sw_we,
  input  wire logic [7:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  output logic      [7:0] sw_rdata,
  // PHY status, index 0 is port 1
  input  wire logic [1:0] an_done,
  input  wire logic [1:0] far_fault,
  input  wire logic [1:0] link_up,
  // PHY controls
  output logic      [1:0] loopback_en,
  output logic      [1:0] force_straight_pinout,
  output logic      [1:0] xover_auto_en,
  output logic      [1:0] crossover_algorithm_select,
  output logic      [1:0] fef_detect_en,
  output logic     [15:0] ctrl_p1,
  output logic     [15:0] ctrl_p2,
  output logic     [15:0] adv_p1,
  output logic     [15:0] adv_p2,
  // Symbol paths
  input  wire logic [4:0] rx_sym_p1,
  input  wire logic [4:0] rx_sym_p2,
  input  wire logic [4:0] mac_sym_p1,
  input  wire logic [4:0] mac_sym_p2,
  output logic      [4:0] tx_sym_p1,
  output logic      [4:0] tx_sym_p2
);

  // ----------------------------------------------------------------
  // Switch address decode
  // ----------------------------------------------------------------
  // Returns {valid, port, select}
  function automatic logic [3:0] sw_decode(input logic [7:0] a);
    case (a)
      SW_R28:  sw_decode = {2'b10, SEL_R28};
      SW_R29:  sw_decode = {2'b10, SEL_R29};
      SW_R31:  sw_decode = {2'b10, SEL_R31};
      SW_R44:  sw_decode = {2'b11, SEL_R28};
      SW_R45:  sw_decode = {2'b11, SEL_R29};
      SW_R47:  sw_decode = {2'b11, SEL_R31};
      default: sw_decode = 4'h0;
    endcase
  endfunction : sw_decode

  pmr_port_if pif [2] (.clk(clk), .reset_n(reset_n));

  logic [3:0]  sw_dec;
  logic [7:0]  sw_rdata_d, sw_rdata_q;
  logic        mi_we;
  logic [15:0] rd_word;

  pmr_state_e  st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [15:0] sr_q, sr_d;
  logic        op_rd_q, op_rd_d;
  logic        hit_q, hit_d;
  logic        port_q, port_d;
  logic [4:0]  idx_q, idx_d;
  logic        mo_q, mo_d;
  logic        oen_q, oen_d;
  logic [11:0] hdr;
  logic [4:0]  tx1_d, tx1_q;
  logic [4:0]  tx2_d, tx2_q;

  logic        mdc_s1, mdc_s2, mdc_s3;
  logic        mdio_s1, mdio_s2;
  logic        mdc_rise;

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  // Both pins pass two flops; the edge detector compares the second mdc stage with a third flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {mdc_s3, mdc_s2, mdc_s1} <= 3'b000;
      {mdio_s2, mdio_s1}       <= 2'b11;
    end else begin
      {mdc_s3, mdc_s2, mdc_s1} <= {mdc_s2, mdc_s1, mdc};
      {mdio_s2, mdio_s1}       <= {mdio_s1, mdio_i};
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_s3;
  assign hdr      = {sr_q[10:0], mdio_s2};

  // ----------------------------------------------------------------
  // Register sets
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    pmr_port_regs #(
      .ID_UPPER (ID_UPPER),
      .ID_LOWER (ID_LOWER)
    ) u_regs (
      .pif (pif[p])
    );
    // Per-port request wiring; bit 0 of each status bus is port 1
    assign pif[p].mi_we     = mi_we & (port_q == 1'(p));
    assign pif[p].mi_idx    = idx_q;
    assign pif[p].mi_wdata  = {sr_q[14:0], mdio_s2};
    assign pif[p].sw_we     = sw_we & sw_dec[3] & (sw_dec[2] == 1'(p));
    assign pif[p].sw_sel    = sw_dec[1:0];
    assign pif[p].sw_wdata  = sw_wdata;
    assign pif[p].an_done   = an_done[p];
    assign pif[p].far_fault = far_fault[p];
    assign pif[p].link_up   = link_up[p];
  end

  // Switch decode and read word of the addressed PHY
  assign sw_dec  = sw_decode(sw_addr);
  assign rd_word = port_q ? pif[1].mi_rdata : pif[0].mi_rdata;

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  // Advances only on a sampled clock edge; preamble suppression is not offered
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sr_d    = sr_q;
    op_rd_d = op_rd_q;
    hit_d   = hit_q;
    port_d  = port_q;
    idx_d   = idx_q;
    mo_d    = mo_q;
    oen_d   = oen_q;
    mi_we   = 1'b0;
    if (mdc_rise) begin
      case (st_q)
        ST_PRE: begin
          if (mdio_s2) begin
            cnt_d = (cnt_q == PRE_LEN) ? cnt_q : cnt_q + 6'h01;
          end else if (cnt_q == PRE_LEN) begin
            st_d = ST_START;
          end else begin
            cnt_d = 6'h00;
          end
        end
        ST_START: begin
          cnt_d = 6'h00;
          st_d  = mdio_s2 ? ST_HDR : ST_PRE;
        end
        ST_HDR: begin
          sr_d  = {sr_q[14:0], mdio_s2};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == HDR_LAST) begin
            cnt_d = 6'h00;
            // RL1 address match
            hit_d   = (hdr[9:5] == PHY1_ADDR) || (hdr[9:5] == PHY2_ADDR);
            port_d  = (hdr[9:5] == PHY2_ADDR);
            idx_d   = hdr[4:0];
            op_rd_d = (hdr[11:10] == OP_RD);
            st_d    = ((hdr[11:10] == OP_RD) || (hdr[11:10] == OP_WR)) ? ST_TA : ST_PRE;
          end
        end
        ST_TA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00 && op_rd_q && hit_q) begin
            oen_d = 1'b0;  // Second turnaround bit driven low
            mo_d  = 1'b0;
          end
          if (cnt_q == 6'h01) begin
            cnt_d = 6'h00;
            sr_d  = rd_word;
            mo_d  = rd_word[15];
            st_d  = op_rd_q ? ST_RDATA : ST_WDATA;
          end
        end
        ST_RDATA: begin
          cnt_d = cnt_q + 6'h01;
          sr_d  = {sr_q[14:0], 1'b0};
          mo_d  = sr_q[14];
          if (cnt_q == DATA_LAST) begin
            cnt_d = 6'h00;
            oen_d = 1'b1;
            mo_d  = 1'b1;
            st_d  = ST_PRE;
          end
        end
        ST_WDATA: begin
          cnt_d = cnt_q + 6'h01;
          sr_d  = {sr_q[14:0], mdio_s2};
          if (cnt_q == DATA_LAST) begin
            cnt_d = 6'h00;
            mi_we = hit_q;  // Frames for other PHYs are ignored
            st_d  = ST_PRE;
          end
        end
        default: begin
          st_d  = ST_PRE;
          cnt_d = 6'h00;
          oen_d = 1'b1;
        end
      endcase
    end
  end

  // Decoder state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= ST_PRE;
      cnt_q   <= 6'h00;
      sr_q    <= 16'h0000;
      op_rd_q <= 1'b0;
      hit_q   <= 1'b0;
      port_q  <= 1'b0;
      idx_q   <= 5'h00;
      mo_q    <= 1'b1;
      oen_q   <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sr_q    <= sr_d;
      op_rd_q <= op_rd_d;
      hit_q   <= hit_d;
      port_q  <= port_d;
      idx_q   <= idx_d;
      mo_q    <= mo_d;
      oen_q   <= oen_d;
    end
  end

  assign mdio_o    = mo_q;
  assign mdio_oe_n = oen_q;

  // ----------------------------------------------------------------
  // Switch read data and symbol loopback
  // ----------------------------------------------------------------
  // Loopback wraps at the far PHY, so the originating port sees its own traffic
  always_comb begin
    sw_rdata_d = 8'h00;
    if (sw_dec[3]) begin
      sw_rdata_d = sw_dec[2] ? pif[1].sw_rdata : pif[0].sw_rdata;
    end
    // RL4 port 1 wrap
    tx2_d = pif[0].ctrl[CB_LPBK] ? rx_sym_p2 : mac_sym_p2;
    // RL5 port 2 wrap
    tx1_d = pif[1].ctrl[CB_LPBK] ? rx_sym_p1 : mac_sym_p1;
  end

  // Output data flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_rdata_q <= 8'h00;
      tx1_q      <= 5'h00;
      tx2_q      <= 5'h00;
    end else begin
      sw_rdata_q <= sw_rdata_d;
      tx1_q      <= tx1_d;
      tx2_q      <= tx2_d;
    end
  end

  assign sw_rdata  = sw_rdata_q;
  assign tx_sym_p1 = tx1_q;
  assign tx_sym_p2 = tx2_q;

  // Control outputs straight from the stored fields
  // RL3 RL7 RL8 RL9 RL10 control fields
  assign loopback_en                = {pif[1].ctrl[CB_LPBK], pif[0].ctrl[CB_LPBK]};
  assign force_straight_pinout      = {pif[1].ctrl[CB_FSTR], pif[0].ctrl[CB_FSTR]};
  assign xover_auto_en              = ~{pif[1].ctrl[CB_DMDIX], pif[0].ctrl[CB_DMDIX]};
  assign crossover_algorithm_select = {pif[1].ctrl[CB_XSEL], pif[0].ctrl[CB_XSEL]};
  assign fef_detect_en              = ~{pif[1].ctrl[CB_DFEF], pif[0].ctrl[CB_DFEF]};
  assign ctrl_p1 = pif[0].ctrl;
  assign ctrl_p2 = pif[1].ctrl;
  assign adv_p1  = pif[0].adv;
  assign adv_p2  = pif[1].adv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  drive_on_hit_a: assert property ($fell(mdio_oe_n) |-> (hit_q && op_rd_q && st_q == ST_TA))  // RL1
    else $error("pin driven without address match");
  drive_span_a: assert property ((st_q == ST_RDATA) |-> (mdio_oe_n == !hit_q))  // RL1
    else $error("read data not driven for own address");
  wrap_p1_a: assert property (loopback_en[0] |=> (tx_sym_p2 == $past(rx_sym_p2)))  // RL4
    else $error("port 1 loopback path wrong");
  wrap_p2_a: assert property (loopback_en[1] |=> (tx_sym_p1 == $past(rx_sym_p1)))  // RL5
    else $error("port 2 loopback path wrong");
  lpbk_write_a: assert property ((mi_we && !port_q && idx_q == IDX_CTRL && !sw_we)
                                 |=> (loopback_en[0] == $past(pif[0].mi_wdata[CB_LPBK])))  // RL3
    else $error("loopback bit not stored");
  pinout_a: assert property ((pif[1].sw_we && !pif[1].mi_we && pif[1].sw_sel == SEL_R29) |=>  // RL7
    (force_straight_pinout[1] == $past(sw_wdata[1]))) else $error("pinout control mismatch");
  xover_a: assert property ((mi_we && !port_q && idx_q == IDX_CTRL && !sw_we) |=>  // RL8
    (xover_auto_en[0] == !$past(pif[0].mi_wdata[CB_DMDIX]))) else $error("crossover enable mismatch");
  sw_read_a: assert property ((sw_addr == SW_R29) |=> (sw_rdata[0] == $past(ctrl_p1[CB_LPBK])))  // RL6
    else $error("switch view of loopback wrong");
  adv_write_a: assert property ((mi_we && port_q && idx_q == IDX_ADV && !sw_we)
                                |=> (adv_p2[8:5] == $past(pif[1].mi_wdata[8:5])))  // RL19
    else $error("ability bits not stored");

  read_frame_c:  cover property ((st_q == ST_RDATA) && !mdio_oe_n);
  write_frame_c: cover property (mi_we && hit_q);
  loopback_c:    cover property ($rose(loopback_en[0]));

endmodule : pmr_top

// ---- inc/pmr_pkg.sv ----
// ----------------------------------------------------------------
// Shared constants for the PHY management register bank
// ----------------------------------------------------------------
package pmr_pkg;

  // Default management addresses of the two PHYs
  localparam logic [4:0] PHY1_ADDR  = 5'h01;
  localparam logic [4:0] PHY2_ADDR  = 5'h02;

  // Register indices
  localparam logic [4:0] IDX_CTRL   = 5'h00;
  localparam logic [4:0] IDX_STAT   = 5'h01;
  localparam logic [4:0] IDX_IDU    = 5'h02;
  localparam logic [4:0] IDX_IDL    = 5'h03;
  localparam logic [4:0] IDX_ADV    = 5'h04;

  // Control register fields
  localparam int CB_LPBK  = 14;
  localparam int CB_F100  = 13;
  localparam int CB_AN_EN = 12;
  localparam int CB_PDN   = 11;
  localparam int CB_RAN   = 9;
  localparam int CB_FDX   = 8;
  localparam int CB_XSEL  = 5;
  localparam int CB_FSTR  = 4;
  localparam int CB_DMDIX = 3;
  localparam int CB_DFEF  = 2;
  localparam int CB_DTX   = 1;
  localparam int CB_DLED  = 0;

  // Advertisement and status fields
  localparam int AB_PAUSE   = 10;
  localparam int AB_ABIL_LO = 5;
  localparam int SB_ANDONE  = 5;
  localparam int SB_FEF     = 4;
  localparam int SB_ANABLE  = 3;
  localparam int SB_LINK    = 2;

  // Reset values and writable masks
  localparam logic [15:0] CTRL_RST   = 16'h1020;
  localparam logic [15:0] CTRL_WMASK = 16'h7b3f;
  localparam logic [15:0] ADV_RST    = 16'h05e1;
  localparam logic [15:0] ADV_WMASK  = 16'h07e0;
  localparam logic [15:0] STAT_FIXED = 16'h7800;

  // Switch-side mirror register numbers
  localparam logic [7:0] SW_R28 = 8'h1c;
  localparam logic [7:0] SW_R29 = 8'h1d;
  localparam logic [7:0] SW_R31 = 8'h1f;
  localparam logic [7:0] SW_R44 = 8'h2c;
  localparam logic [7:0] SW_R45 = 8'h2d;
  localparam logic [7:0] SW_R47 = 8'h2f;
  localparam logic [1:0] SEL_R28 = 2'h0;
  localparam logic [1:0] SEL_R29 = 2'h1;
  localparam logic [1:0] SEL_R31 = 2'h2;

  // Frame fields and bit counts
  localparam logic [1:0] OP_RD     = 2'h2;
  localparam logic [1:0] OP_WR     = 2'h1;
  localparam logic [5:0] PRE_LEN   = 6'h20;
  localparam logic [5:0] HDR_LAST  = 6'h0b;
  localparam logic [5:0] DATA_LAST = 6'h0f;

  // Frame decoder states
  typedef enum logic [2:0] {
    ST_PRE   = 3'b000,
    ST_START = 3'b001,
    ST_HDR   = 3'b010,
    ST_TA    = 3'b011,
    ST_RDATA = 3'b100,
    ST_WDATA = 3'b101
  } pmr_state_e;

endpackage : pmr_pkg

// ---- inc/pmr_port_if.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link between frame decoder and one PHY's register set
// ----------------------------------------------------------------
interface pmr_port_if (
  input wire logic clk,
  input wire logic reset_n
);
  logic        mi_we;
  logic [4:0]  mi_idx;
  logic [15:0] mi_wdata;
  logic [15:0] mi_rdata;
  logic        sw_we;
  logic [1:0]  sw_sel;
  logic [7:0]  sw_wdata;
  logic [7:0]  sw_rdata;
  logic        an_done;
  logic        far_fault;
  logic        link_up;
  logic [15:0] ctrl;
  logic [15:0] adv;

  modport top (input clk, reset_n, mi_rdata, sw_rdata, ctrl, adv,
               output mi_we, mi_idx, mi_wdata, sw_we, sw_sel, sw_wdata, an_done, far_fault, link_up);
  modport port (input clk, reset_n, mi_we, mi_idx, mi_wdata, sw_we, sw_sel, sw_wdata, an_done, far_fault,
                link_up, output mi_rdata, sw_rdata, ctrl, adv);
endinterface : pmr_port_if

// ---- verilog/pmr_port_regs.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register set of one PHY
// ----------------------------------------------------------------
module pmr_port_regs
  import pmr_pkg::*;
#(
  parameter logic [15:0] ID_UPPER = 16'ha5a0,  // Arbitrary value
  parameter logic [15:0] ID_LOWER = 16'h0f10   // Arbitrary value
) (
  // Decoder side
  pmr_port_if.port pif
);

  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] adv_q;
  logic [15:0] adv_d;
  logic [15:0] stat_w;

  // Status word; fault bit masked while detection is switched off
  // RL11 RL12 RL13 RL14 RL15 RL16 status bits
  always_comb begin
    stat_w            = STAT_FIXED;
    stat_w[SB_ANDONE] = pif.an_done;
    stat_w[SB_FEF]    = pif.far_fault & ~ctrl_q[CB_DFEF];
    stat_w[SB_ANABLE] = ctrl_q[CB_AN_EN];
    stat_w[SB_LINK]   = pif.link_up;
  end

  // Management read mux; unsupported indices read zero
  always_comb begin
    // RL2 RL17 identifiers, unsupported zero
    case (pif.mi_idx)
      IDX_CTRL: pif.mi_rdata = ctrl_q;
      IDX_STAT: pif.mi_rdata = stat_w;
      IDX_IDU:  pif.mi_rdata = ID_UPPER;
      IDX_IDL:  pif.mi_rdata = ID_LOWER;
      IDX_ADV:  pif.mi_rdata = adv_q;
      default:  pif.mi_rdata = 16'h0000;
    endcase
  end

  // Switch-side view of the same storage
  always_comb begin
    case (pif.sw_sel)
      SEL_R28: pif.sw_rdata = {ctrl_q[CB_AN_EN], ctrl_q[CB_F100], ctrl_q[CB_FDX], adv_q[AB_PAUSE],
                               adv_q[AB_ABIL_LO+3:AB_ABIL_LO]};
      SEL_R29: pif.sw_rdata = {ctrl_q[CB_DLED], ctrl_q[CB_DTX], ctrl_q[CB_RAN], ctrl_q[CB_DFEF],
                               ctrl_q[CB_PDN], ctrl_q[CB_DMDIX], ctrl_q[CB_FSTR], ctrl_q[CB_LPBK]};
      SEL_R31: pif.sw_rdata = {ctrl_q[CB_XSEL], 6'h00, stat_w[SB_FEF]};
      default: pif.sw_rdata = 8'h00;
    endcase
  end

  // Next values; a management write wins over a switch write in the same cycle
  always_comb begin
    ctrl_d = ctrl_q;
    adv_d  = adv_q;
    if (pif.sw_we) begin
      // RL6 shared switch storage
      case (pif.sw_sel)
        SEL_R28: begin
          ctrl_d[CB_AN_EN] = pif.sw_wdata[7];
          ctrl_d[CB_F100]  = pif.sw_wdata[6];
          ctrl_d[CB_FDX]   = pif.sw_wdata[5];
          adv_d[AB_PAUSE]  = pif.sw_wdata[4];
          adv_d[AB_ABIL_LO+3:AB_ABIL_LO] = pif.sw_wdata[3:0];
        end
        SEL_R29: begin
          ctrl_d[CB_DLED]  = pif.sw_wdata[7];
          ctrl_d[CB_DTX]   = pif.sw_wdata[6];
          ctrl_d[CB_RAN]   = pif.sw_wdata[5];
          ctrl_d[CB_DFEF]  = pif.sw_wdata[4];
          ctrl_d[CB_PDN]   = pif.sw_wdata[3];
          ctrl_d[CB_DMDIX] = pif.sw_wdata[2];
          ctrl_d[CB_FSTR]  = pif.sw_wdata[1];
          ctrl_d[CB_LPBK]  = pif.sw_wdata[0];
        end
        SEL_R31: begin
          ctrl_d[CB_XSEL]  = pif.sw_wdata[7];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    if (pif.mi_we) begin
      // RL20 fixed bits masked
      if (pif.mi_idx == IDX_CTRL) begin
        ctrl_d = (ctrl_q & ~CTRL_WMASK) | (pif.mi_wdata & CTRL_WMASK);
      end
      if (pif.mi_idx == IDX_ADV) begin
        adv_d = (adv_q & ~ADV_WMASK) | (pif.mi_wdata & ADV_WMASK);
      end
    end
  end

  // Storage; RL3 RL9 RL18 RL19 reset values
  always_ff @(posedge pif.clk or negedge pif.reset_n) begin
    if (!pif.reset_n) begin
      ctrl_q <= CTRL_RST;
      adv_q  <= ADV_RST;
    end else begin
      ctrl_q <= ctrl_d;
      adv_q  <= adv_d;
    end
  end

  assign pif.ctrl = ctrl_q;
  assign pif.adv  = adv_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pif.clk); endclocking
  default disable iff (!pif.reset_n);

  stat_fixed_bits_a: assert property ((stat_w & 16'hf981) == 16'h7800)  // RL11 RL12 RL16
    else $error("status fixed bits wrong");
  an_done_bit_a: assert property (stat_w[SB_ANDONE] == pif.an_done)  // RL13
    else $error("negotiation done bit wrong");
  fef_bit_a: assert property (stat_w[SB_FEF] == (pif.far_fault & ~ctrl_q[CB_DFEF]))  // RL14 RL10
    else $error("far-end fault bit wrong");
  an_able_bit_a: assert property (stat_w[SB_ANABLE] == ctrl_q[CB_AN_EN])  // RL15
    else $error("negotiation able bit wrong");
  id_words_a: assert property ((pif.mi_idx == IDX_IDU) |-> (pif.mi_rdata == ID_UPPER))  // RL17
    else $error("upper identifier wrong");
  unsup_index_a: assert property ((pif.mi_idx > IDX_ADV) |-> (pif.mi_rdata == 16'h0000))  // RL2
    else $error("unsupported index not zero");
  fixed_ctrl_kept_a: assert property (pif.mi_we |=> ((ctrl_q & ~CTRL_WMASK) == 16'h0000)
                                      && (adv_q[4:0] == 5'h01))  // RL20
    else $error("fixed bits changed by write");
  mirror_lpbk_a: assert property ((pif.sw_we && !pif.mi_we && pif.sw_sel == SEL_R29)
                                  |=> (ctrl_q[CB_LPBK] == $past(pif.sw_wdata[0])))  // RL6
    else $error("loopback mirror not updated");
  pause_mirror_a: assert property ((pif.sw_we && !pif.mi_we && pif.sw_sel == SEL_R28)
                                   |=> (adv_q[AB_PAUSE] == $past(pif.sw_wdata[4])))  // RL18
    else $error("pause mirror not updated");

endmodule : pmr_port_regs

// ---- verification/pmr_sta.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Station controller model on the management link
// ------------------------------------------------
module pmr_sta
  import pmr_pkg::*;
(
  // Link pins, drive high means released
  output logic      mdc,
  output logic      mdio_drv,
  input  wire logic mdio_in
);
  // Link clock stands low between frames
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
  end
  // One 160 ns link bit, data set while clock low
  task automatic bit_cyc(input logic b, output logic s);
    mdio_drv = b;
    #80 mdc = 1'b1;
    s = mdio_in;
    #80 mdc = 1'b0;
  endtask : bit_cyc
  // Whole frame; a read releases the line from turnaround on
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] f;
    logic        s;
    f = {32'hffff_ffff, 2'b01, op, pa, ra, (op == OP_RD) ? 18'h3_ffff : {2'b10, wd}};
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(f[i], s);
      if (i < 16) rd[i] = s;
    end
    mdio_drv = 1'b1;
    #320;
  endtask : xfer
endmodule : pmr_sta

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Bench for the PHY management register bank
// ------------------------------------------------
module tb;
  import pmr_pkg::*;
  localparam logic [15:0] IDU = 16'h3c3c;  // Arbitrary value
  localparam logic [15:0] IDL = 16'h0c0c;  // Arbitrary value
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mdc, mdio_drv, mdio_o, mdio_oe_n, sw_we = 1'b0;
  logic [7:0]  sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata;
  logic [1:0]  an_done = 2'h0, far_fault = 2'h0, link_up = 2'h0, lpbk, fstr, xauto, xsel, fefen;
  logic [4:0]  rx1 = 5'h00, rx2 = 5'h00, mac1 = 5'h00, mac2 = 5'h00, tx1, tx2;
  logic [15:0] res, rdw, wv, c1, c2, a1, a2;
  logic [15:0] q[$];
  int          num_errors = 0, checks = 0;
  event        res_ev;
  // Pull-up on the data line unless a party drives low
  wire mdio_w = (mdio_oe_n | mdio_o) & mdio_drv;
  always #5 clk = ~clk;
  pmr_sta pmr_sta_inst (.mdc(mdc), .mdio_drv(mdio_drv), .mdio_in(mdio_w));
  pmr_top #(.ID_UPPER(IDU), .ID_LOWER(IDL)) pmr_top_inst (.clk(clk), .reset_n(reset_n), .mdc(mdc),
    .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .sw_we(sw_we), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_rdata(sw_rdata), .an_done(an_done), .far_fault(far_fault), .link_up(link_up),
    .loopback_en(lpbk), .force_straight_pinout(fstr), .xover_auto_en(xauto), .crossover_algorithm_select(xsel),
    .fef_detect_en(fefen), .ctrl_p1(c1), .ctrl_p2(c2), .adv_p1(a1), .adv_p2(a2), .rx_sym_p1(rx1), .rx_sym_p2(rx2),
    .mac_sym_p1(mac1), .mac_sym_p2(mac2), .tx_sym_p1(tx1), .tx_sym_p2(tx2));
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Watcher pairs each result with the oldest note
  always @(res_ev) chk(q.pop_front(), res);
  task automatic post(input logic [15:0] e, g);
    q.push_back(e);
    res = g;
    ->res_ev;
    #1;
  endtask : post
  task automatic rd(input logic [4:0] pa, ra, input logic [15:0] e);
    pmr_sta_inst.xfer(OP_RD, pa, ra, 16'h0000, rdw);
    post(e, rdw);
  endtask : rd
  task automatic sw(input logic [7:0] a, d);
    @(posedge clk) #1;
    sw_we = 1'b1;
    sw_addr = a;
    sw_wdata = d;
    @(posedge clk) #1;
    sw_we = 1'b0;
  endtask : sw
  task automatic swrd(input logic [7:0] a, e);
    @(posedge clk) #1 sw_addr = a;
    repeat (2) @(posedge clk);
    #1 post({8'h00, e}, {8'h00, sw_rdata});
  endtask : swrd
  // Symbol paths and port 1 controls in one word; symbols held so routing shows
  task automatic pins(input logic l1, l2, input logic [3:0] f);
    @(posedge clk) #1 {rx1, rx2, mac1, mac2} = 20'($urandom);
    repeat (3) @(posedge clk);
    #1 post({l2 ? rx1 : mac1, l1 ? rx2 : mac2, l2, l1, f}, {tx1, tx2, lpbk, fstr[0], xauto[0], xsel[0], fefen[0]});
  endtask : pins
  initial begin
    void'($urandom(97));
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    {an_done, far_fault, link_up} = 6'($urandom);
    rd(PHY1_ADDR, IDX_IDU, IDU);
    rd(PHY2_ADDR, IDX_IDL, IDL);
    rd(PHY1_ADDR, IDX_CTRL, CTRL_RST);
    rd(PHY2_ADDR, IDX_ADV, ADV_RST);
    rd(PHY2_ADDR, IDX_STAT, {8'h78, 2'b00, an_done[1], far_fault[1], 1'b1, link_up[1], 2'b00});
    pins(1'b0, 1'b0, 4'b0111);
    pmr_sta_inst.xfer(OP_WR, PHY1_ADDR, IDX_CTRL, 16'hffff, rdw);
    post(CTRL_WMASK, c1);
    rd(PHY1_ADDR, IDX_CTRL, CTRL_WMASK);
    rd(PHY1_ADDR, IDX_STAT, {8'h78, 2'b00, an_done[0], 1'b0, 1'b1, link_up[0], 2'b00});
    pins(1'b1, 1'b0, 4'b1010);
    swrd(SW_R29, 8'hff);
    pmr_sta_inst.xfer(OP_WR, PHY1_ADDR, IDX_CTRL, 16'h0000, rdw);
    pins(1'b0, 1'b0, 4'b0101);
    swrd(SW_R29, 8'h00);
    sw(SW_R45, 8'h01);
    rd(PHY2_ADDR, IDX_CTRL, 16'h5020);
    pins(1'b0, 1'b1, 4'b0101);
    // Foreign address and fixed places take no writes
    pmr_sta_inst.xfer(OP_WR, 5'h03, IDX_CTRL, 16'h0000, rdw);
    rd(5'h03, IDX_CTRL, 16'hffff);
    rd(PHY2_ADDR, IDX_CTRL, 16'h5020);
    pmr_sta_inst.xfer(OP_WR, PHY2_ADDR, IDX_IDU, 16'h0000, rdw);
    rd(PHY2_ADDR, IDX_IDU, IDU);
    rd(PHY1_ADDR, 5'h06, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wv = 16'($urandom);
      pmr_sta_inst.xfer(OP_WR, PHY2_ADDR, IDX_ADV, wv, rdw);
      rd(PHY2_ADDR, IDX_ADV, (wv & ADV_WMASK) | 16'h0001);
    end
    swrd(SW_R44, {3'b100, wv[10], wv[8:5]});
    // Switch-side write of the ability byte shows in the management view
    sw(SW_R44, 8'h5a);
    rd(PHY2_ADDR, IDX_ADV, {5'h00, 1'b1, wv[9], 4'ha, 5'h01});
    rd(PHY2_ADDR, IDX_STAT, {8'h78, 2'b00, an_done[1], far_fault[1], 1'b0, link_up[1], 2'b00});
    post(16'h6020, c2);
    post({5'h00, 1'b1, wv[9], 4'ha, 5'h01}, a2);
    post(ADV_RST, a1);
    post(16'h0007, {12'h000, fstr[1], xauto[1], xsel[1], fefen[1]});
    test_done();
  end
  // Twenty-six frames of about 10.6 us, with wide margin
  initial begin
    #800_000;
    num_errors++;
    test_done();
  end
endmodule : tb
